// >>> hdl/acc_detect_ctrl.sv
// accessory detect control and status with an axi4-lite register slave
`include "acc_detect_defs.svh"
`default_nettype none
module acc_detect_ctrl #(
    parameter int QMS_CYC = `QMS_NS / `CLK_NS,
    parameter int AW      = 12
) (
    input  wire logic          i_mclk,
    input  wire logic          i_rst_n,
    input  wire logic [AW-1:0] i_awaddr,
    input  wire logic          i_awvalid,
    output logic               o_awready,
    input  wire logic [31:0]   i_wdata,
    input  wire logic [3:0]    i_wstrb,
    input  wire logic          i_wvalid,
    output logic               o_wready,
    output logic [1:0]         o_bresp,
    output logic               o_bvalid,
    input  wire logic          i_bready,
    input  wire logic [AW-1:0] i_araddr,
    input  wire logic          i_arvalid,
    output logic               o_arready,
    output logic [31:0]        o_rdata,
    output logic [1:0]         o_rresp,
    output logic               o_rvalid,
    input  wire logic          i_rready,
    output logic               o_irq,
    output logic [1:0]         o_measurement_select,
    output logic               o_sense_pin_select,
    output logic               o_sense_reference_select,
    output logic               o_ground_feedback_select,
    output logic               o_ramp_rate_select,
    output logic               o_sense_tick,
    output logic               o_ramp_up,
    output logic               o_ramp_down,
    output logic               o_mic_sample,
    output logic               o_mic_sense_enable,
    input  wire logic          i_ramp_trip,
    input  wire logic [6:0]    i_load_level,
    input  wire logic          i_ramp_empty,
    input  wire logic          i_bias_on,
    input  wire logic          i_mic_ready,
    input  wire logic [8:0]    i_mic_level
);
    import acc_detect_pkg::*;

    localparam int DET_CYC = `CLK_HZ / `DET_HZ;
    localparam state_t ST_RST = '{dwell: `RST_DWELL, settle: `RST_SETTLE,
        rate: `RST_RATE, mask: `RST_MASK, hp: HP_IDLE, mic: MIC_IDLE, default: '0};

    state_t st_reg;
    state_t st_next;
    logic   rst_s1;
    logic   rst_n;
    logic   wr_go;
    logic   rd_go;
    logic   trig_wr;
    logic [15:0] wr_val;
    logic [8:0]  mic_lvl;
    logic [2:0]  agree_new;

    // ****************************************
    // helper functions
    // ****************************************
    // dwell in detect clock cycles for each code
    function automatic logic [10:0] dwell_cyc(input logic [2:0] c);
        case (c)
            3'h0:    dwell_cyc = 11'h001;
            3'h1:    dwell_cyc = 11'h004;
            3'h2:    dwell_cyc = 11'h010;
            3'h3:    dwell_cyc = 11'h040;
            3'h4:    dwell_cyc = 11'h100;
            3'h5:    dwell_cyc = 11'h200;
            3'h6:    dwell_cyc = 11'h300;
            default: dwell_cyc = 11'h400;
        endcase
    endfunction : dwell_cyc

    // delay code to quarter-millisecond ticks, doubling per code up to code 12
    function automatic logic [11:0] qms_ticks(input logic [3:0] c);
        if (c == 4'h0)
            qms_ticks = 12'h000;
        else if (c >= `DLY_SAT)
            qms_ticks = `DLY_MAX;
        else
            qms_ticks = 12'h001 << (c - 4'h1);
    endfunction : qms_ticks

    // ****************************************
    // reset release and state register
    // ****************************************
    // two-stage release of the asynchronous reset, kept apart from the state
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            {rst_n, rst_s1} <= 2'b00;
        else
            {rst_n, rst_s1} <= {rst_s1, 1'b1};
    end
    // all other state, reset by the released copy
    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= ST_RST;
        else
            st_reg <= st_next;
    end

    // ****************************************
    // combinational decode
    // ****************************************
    assign wr_go   = st_reg.awv && st_reg.wv && !st_reg.bvalid;
    assign rd_go   = i_arvalid && !st_reg.rvalid;
    assign trig_wr = wr_go && st_reg.awidx == `IDX_HPC && st_reg.wstrb[0]
                     && st_reg.wdata[`F_TRIG];
    assign wr_val  = st_reg.wdata;
    // range gating, unused level bit 7 and mask bit 6 never reach the vector
    assign mic_lvl = {i_mic_level[8] & st_reg.mask[7], 1'b0,
                      i_mic_level[6:1] & st_reg.mask[5:0], i_mic_level[0]};
    assign agree_new = (mic_lvl == st_reg.last && st_reg.agree != 3'h0)
                       ? ((st_reg.agree == `DB_LONG) ? `DB_LONG : st_reg.agree + 3'h1)
                       : 3'h1;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb
    begin
        st_next        = st_reg;
        st_next.tick   = 1'b0;
        st_next.sample = 1'b0;

        // detect clock: 32 kHz base then divide by 1, 2, 4 or 8
        if (st_reg.pre == 12'(DET_CYC - 1))
        begin
            st_next.pre  = 12'h000;
            st_next.sub  = st_reg.sub + 3'h1;
            st_next.tick = (st_reg.sub & ((3'h1 << st_reg.cdiv) - 3'h1)) == 3'h0;
        end
        else
            st_next.pre = st_reg.pre + 12'h001;

        // quarter millisecond tick for settle and poll delays
        st_next.qtick = st_reg.qcnt == 16'(QMS_CYC - 1);
        st_next.qcnt  = st_next.qtick ? 16'h0000 : st_reg.qcnt + 16'h0001;

        // axi address and data capture, each held until the write is done
        if (i_awvalid && !st_reg.awv)
        begin
            st_next.awv   = 1'b1;
            st_next.awidx = i_awaddr[9:2];
        end
        if (i_wvalid && !st_reg.wv)
        begin
            st_next.wv    = 1'b1;
            st_next.wdata = i_wdata[15:0];
            st_next.wstrb = i_wstrb[1:0];
        end
        if (st_reg.bvalid && i_bready)
            st_next.bvalid = 1'b0;
        if (st_reg.rvalid && i_rready)
            st_next.rvalid = 1'b0;

        // register writes
        if (wr_go)
        begin
            st_next.awv    = 1'b0;
            st_next.wv     = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = 2'h0;
            case (st_reg.awidx)
                `IDX_MODE:
                    if (st_reg.wstrb[0])
                        st_next.mode = wr_val[`F_MODE];
                `IDX_PIN:
                    if (st_reg.wstrb[0])
                        st_next.pin = wr_val[2:0];
                `IDX_HPC:
                    if (st_reg.wstrb[0])
                    begin
                        st_next.dwell = wr_val[`F_DWELL];
                        st_next.cdiv  = wr_val[`F_CDIV];
                        st_next.step  = wr_val[`F_STEP];
                        if (wr_val[`F_TRIG] && st_reg.hp == HP_IDLE)
                        begin
                            st_next.trig = 1'b1;
                            st_next.done = 1'b0;
                        end
                    end
                `IDX_MICC:
                begin
                    if (st_reg.wstrb[1])
                        {st_next.settle, st_next.rate} = wr_val[15:8];
                    if (st_reg.wstrb[0])
                    begin
                        st_next.dbt = wr_val[`F_DBT];
                        st_next.men = wr_val[`F_MEN];
                    end
                end
                `IDX_MASK:
                    if (st_reg.wstrb[0])
                        st_next.mask = wr_val[7:0];
                `IDX_IRQ_STS:
                    if (st_reg.wstrb[0])
                        st_next.sts = st_reg.sts & ~wr_val[`F_IRQ];
                `IDX_IRQ_MSK:
                    if (st_reg.wstrb[0])
                        st_next.msk = wr_val[`F_IRQ];
                `IDX_HPR, `IDX_MICR: ;
                default:
                    st_next.bresp = 2'h2;
            endcase
        end

        // register reads, answered the cycle after the address is taken
        if (rd_go)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = 2'h0;
            st_next.rdata  = 16'h0000;
            case (i_araddr[9:2])
                `IDX_MODE:    st_next.rdata = {14'h0, st_reg.mode};
                `IDX_PIN:     st_next.rdata = {13'h0, st_reg.pin};
                `IDX_HPC:     st_next.rdata = {8'h0, st_reg.dwell, st_reg.cdiv, 1'b0,
                                               st_reg.step, st_reg.trig};
                `IDX_HPR:     st_next.rdata = {8'h0, st_reg.done, st_reg.level};
                `IDX_MICC:    st_next.rdata = {st_reg.settle, st_reg.rate, 6'h0,
                                               st_reg.dbt, st_reg.men};
                `IDX_MASK:    st_next.rdata = {8'h0, st_reg.mask};
                `IDX_MICR:    st_next.rdata = {5'h0, st_reg.vec, st_reg.valid,
                                               st_reg.pres};
                `IDX_IRQ_STS: st_next.rdata = {13'h0, st_reg.sts};
                `IDX_IRQ_MSK: st_next.rdata = {13'h0, st_reg.msk};
                default:      st_next.rresp = 2'h2;
            endcase
        end

        // headphone load measurement sequence
        case (st_reg.hp)
            HP_IDLE:
                if (st_reg.trig)
                begin
                    st_next.trig = 1'b0;
                    st_next.hp   = HP_UP;
                end
            HP_UP:
                if (st_reg.tick && i_ramp_trip)
                begin
                    // clamp the reported code to its documented span
                    if (i_load_level < `LOAD_MIN)
                        st_next.level = `LOAD_MIN;
                    else if (i_load_level > `LOAD_MAX)
                        st_next.level = `LOAD_MAX;
                    else
                        st_next.level = i_load_level;
                    st_next.hcnt = dwell_cyc(st_reg.dwell);
                    st_next.hp   = HP_HOLD;
                end
            HP_HOLD:
                if (st_reg.tick)
                begin
                    st_next.hcnt = st_reg.hcnt - 11'h001;
                    if (st_reg.hcnt == 11'h001)
                        st_next.hp = HP_DOWN;
                end
            HP_DOWN:
                if (st_reg.tick && i_ramp_empty)
                begin
                    st_next.done = 1'b1;
                    st_next.sts[`IRQ_HP] = 1'b1;
                    st_next.hp   = HP_IDLE;
                end
            default:
                st_next.hp = HP_IDLE;
        endcase

        // mic impedance polling sequence
        case (st_reg.mic)
            MIC_IDLE:
                if (st_reg.men)
                begin
                    st_next.agree = 3'h0;
                    st_next.dcnt  = qms_ticks(st_reg.settle);
                    if (i_bias_on || st_reg.settle == 4'h0)
                        st_next.mic = MIC_SAMPLE;
                    else
                        st_next.mic = MIC_SETTLE;
                end
            MIC_SETTLE, MIC_GAP:
                if (st_reg.dcnt == 12'h000)
                    st_next.mic = MIC_SAMPLE;
                else if (st_reg.qtick)
                    st_next.dcnt = st_reg.dcnt - 12'h001;
            MIC_SAMPLE:
            begin
                st_next.sample = 1'b1;
                st_next.mic    = MIC_RESULT;
            end
            MIC_RESULT:
                if (i_mic_ready)
                begin
                    st_next.last  = mic_lvl;
                    st_next.agree = agree_new;
                    if (agree_new >= (st_reg.dbt ? `DB_LONG : `DB_SHORT))
                    begin
                        st_next.vec   = mic_lvl;
                        st_next.valid = 1'b1;
                        st_next.pres  = |mic_lvl;
                        st_next.sts[`IRQ_MIC] = 1'b1;
                        if ((|mic_lvl) != st_reg.pres)
                            st_next.sts[`IRQ_PRES] = 1'b1;
                    end
                    st_next.dcnt = qms_ticks(st_reg.rate);
                    st_next.mic  = MIC_GAP;
                end
            default:
                st_next.mic = MIC_IDLE;
        endcase

        // disabling mic detection stops polling and withdraws the result
        if (!st_reg.men)
        begin
            st_next.mic   = MIC_IDLE;
            st_next.valid = 1'b0;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_awready = !st_reg.awv;
    assign o_wready  = !st_reg.wv;
    assign o_bvalid  = st_reg.bvalid;
    assign o_bresp   = st_reg.bresp;
    assign o_arready = !st_reg.rvalid;
    assign o_rvalid  = st_reg.rvalid;
    assign o_rresp   = st_reg.rresp;
    assign o_rdata   = {16'h0000, st_reg.rdata};
    assign o_irq     = |(st_reg.sts & st_reg.msk);

    // front end controls
    assign o_measurement_select     = st_reg.mode;
    assign o_sense_pin_select       = st_reg.pin[`F_SRC];
    assign o_sense_reference_select = st_reg.pin[`F_BIAS];
    assign o_ground_feedback_select = st_reg.pin[`F_FB];
    assign o_ramp_rate_select       = st_reg.step;
    assign o_sense_tick             = st_reg.tick;
    assign o_ramp_up                = st_reg.hp == HP_UP || st_reg.hp == HP_HOLD;
    assign o_ramp_down              = st_reg.hp == HP_DOWN;
    assign o_mic_sample             = st_reg.sample;
    assign o_mic_sense_enable       = st_reg.men;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    a_trig_self_clear: assert property (st_reg.trig && st_reg.hp == HP_IDLE |=>
        !st_reg.trig && st_reg.hp == HP_UP) else $error("trigger did not start");
    a_new_trig_done: assert property (trig_wr && st_reg.hp == HP_IDLE |=>
        !st_reg.done ##1 st_reg.hp == HP_UP) else $error("done not cleared");
    a_done_at_end: assert property (st_reg.hp == HP_DOWN && st_reg.tick && i_ramp_empty
        |=> st_reg.done && st_reg.hp == HP_IDLE) else $error("done not set");
    a_level_clamped: assert property (st_reg.done |-> st_reg.level >= `LOAD_MIN
        && st_reg.level <= `LOAD_MAX) else $error("level out of range");
    a_hold_length: assert property ($rose(st_reg.hp == HP_HOLD) |->
        st_reg.hcnt == dwell_cyc(st_reg.dwell)) else $error("bad dwell");
    a_tick_spacing: assert property (st_reg.tick && st_reg.cdiv == 2'h3 |=>
        !st_reg.tick [*8]) else $error("tick too fast");
    a_mode_write: assert property (wr_go && st_reg.awidx == `IDX_MODE && st_reg.wstrb[0]
        |=> o_measurement_select == $past(st_reg.wdata[1:0])) else $error("mode");
    a_settle_skip: assert property (st_reg.mic == MIC_IDLE && st_reg.men && i_bias_on
        |=> st_reg.mic == MIC_SAMPLE ##1 o_mic_sample) else $error("no skip");
    a_valid_off: assert property (!st_reg.men |=> !st_reg.valid)
        else $error("valid while disabled");
    a_present_vec: assert property (st_reg.valid |-> st_reg.pres == |st_reg.vec
        && !st_reg.vec[7]) else $error("presence mismatch");

    c_load_sense_done:   cover property (st_reg.hp == HP_DOWN ##1 st_reg.done);
    c_mic_valid: cover property ($rose(st_reg.valid));
    c_irq:       cover property ($rose(o_irq));
    c_slverr:    cover property (o_bvalid && o_bresp == 2'h2);
endmodule : acc_detect_ctrl
`default_nettype wire

// >>> hdl/acc_detect_defs.svh
// constants for the accessory detect control block
`ifndef ACC_DETECT_DEFS_SVH
`define ACC_DETECT_DEFS_SVH
// register indices, byte address is four times the index
`define IDX_MODE     8'h30
`define IDX_PIN      8'h31
`define IDX_HPC      8'h34
`define IDX_HPR      8'h35
`define IDX_MICC     8'h38
`define IDX_MASK     8'h39
`define IDX_MICR     8'h3a
`define IDX_IRQ_STS  8'h3c
`define IDX_IRQ_MSK  8'h3d
// field positions
`define F_MODE       1:0
`define F_FB         2
`define F_SRC        1
`define F_BIAS       0
`define F_DWELL      7:5
`define F_CDIV       4:3
`define F_STEP       1
`define F_TRIG       0
`define F_DONE       7
`define F_LEVEL      6:0
`define F_SETTLE     15:12
`define F_RATE       11:8
`define F_DBT        1
`define F_MEN        0
`define F_VEC        10:2
`define F_VALID      1
`define F_PRES       0
`define F_IRQ        2:0
// reset values
`define RST_DWELL    3'h1
`define RST_SETTLE   4'h7
`define RST_RATE     4'h6
`define RST_MASK     8'hbf
// timing
`define CLK_HZ       100000000
`define DET_HZ       32000
`define CLK_NS       10
`define QMS_NS       250000
`define DLY_SAT      4'hc
`define DLY_MAX      12'h800
// load code limits and debounce counts
`define LOAD_MIN     7'h08
`define LOAD_MAX     7'h7e
`define DB_SHORT     3'h2
`define DB_LONG      3'h4
// interrupt status bits
`define IRQ_HP       0
`define IRQ_MIC      1
`define IRQ_PRES     2
`endif

// >>> hdl/acc_detect_pkg.sv
// types for the accessory detect control block
`default_nettype none
package acc_detect_pkg;
    typedef enum logic [1:0] {HP_IDLE, HP_UP, HP_HOLD, HP_DOWN} hp_state_t;
    typedef enum logic [2:0] {MIC_IDLE, MIC_SETTLE, MIC_SAMPLE, MIC_RESULT, MIC_GAP} mic_state_t;
    typedef struct packed {
        logic [1:0]  mode;
        logic [2:0]  pin;
        logic [2:0]  dwell;
        logic [1:0]  cdiv;
        logic        step;
        logic        trig;
        logic        done;
        logic [6:0]  level;
        logic [3:0]  settle;
        logic [3:0]  rate;
        logic        dbt;
        logic        men;
        logic [7:0]  mask;
        logic [8:0]  vec;
        logic        valid;
        logic        pres;
        logic [2:0]  sts;
        logic [2:0]  msk;
        hp_state_t   hp;
        mic_state_t  mic;
        logic [11:0] pre;
        logic [2:0]  sub;
        logic        tick;
        logic [15:0] qcnt;
        logic        qtick;
        logic [10:0] hcnt;
        logic [11:0] dcnt;
        logic        sample;
        logic [8:0]  last;
        logic [2:0]  agree;
        logic        awv;
        logic [7:0]  awidx;
        logic        wv;
        logic [15:0] wdata;
        logic [1:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [15:0] rdata;
    } state_t;
endpackage : acc_detect_pkg
`default_nettype wire

// >>> testbench/fe_model.sv
// behavioural analogue front end and headset for the detect block
`default_nettype none
module fe_model (
    input  wire logic       i_clk,
    input  wire logic       i_tick,
    input  wire logic       i_up,
    input  wire logic       i_down,
    input  wire logic       i_sample,
    input  wire logic [6:0] i_load,
    input  wire logic [8:0] i_imp,
    output logic            o_trip,
    output logic [6:0]      o_level,
    output logic            o_empty,
    output logic            o_ready,
    output logic [8:0]      o_vec
);
    timeunit 1ns;
    timeprecision 1ns;
    logic seen;
    initial {o_trip, o_level, o_empty, o_ready, o_vec, seen} = '0;
    // trips one tick into the ramp; stale level and vector are inverted
    always @(posedge i_clk)
    begin
        seen    <= i_up && (seen || i_tick);
        o_trip  <= seen;
        o_level <= seen ? i_load : ~o_level;
        o_empty <= i_down;
        o_ready <= i_sample;
        o_vec   <= i_sample ? i_imp : ~o_vec;
    end
endmodule : fe_model
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the accessory detect control block
`include "acc_detect_defs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0, bias = 1;
    logic [11:0] aw = '0, ar = '0;
    logic [31:0] wd = '0, rd_d, seed = 32'd21299;
    logic [6:0]  load = '0;
    logic [8:0]  imp = '0;
    logic [7:0]  m;
    logic [2:0]  p;
    logic [1:0]  resp;
    time         t0;
    logic [3:0]  ws = 4'hf;
    int          n_fail = 0, compares = 0, ns = 0, nc = 0;
    wire logic   awr, wrr, bv, arr, rv, irq, trip, empty, tick, up, down, smp, rdy, step, men;
    wire logic [1:0]  br, rr, msel;
    wire logic [2:0]  pins;
    wire logic [31:0] rdata;
    wire logic [6:0]  lvl;
    wire logic [8:0]  vec;
    acc_detect_ctrl #(.QMS_CYC(20)) i_dut (.i_mclk(clk), .i_rst_n(rst_n), .i_awaddr(aw),
        .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv),
        .o_wready(wrr), .o_bresp(br), .o_bvalid(bv), .i_bready(1'b1), .i_araddr(ar),
        .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rr), .o_rvalid(rv),
        .i_rready(1'b1), .o_irq(irq), .o_measurement_select(msel),
        .o_sense_pin_select(pins[1]), .o_sense_reference_select(pins[0]),
        .o_ground_feedback_select(pins[2]), .o_ramp_rate_select(step), .o_sense_tick(tick),
        .o_ramp_up(up), .o_ramp_down(down), .o_mic_sample(smp), .o_mic_sense_enable(men),
        .i_ramp_trip(trip), .i_load_level(lvl), .i_ramp_empty(empty), .i_bias_on(bias),
        .i_mic_ready(rdy), .i_mic_level(vec));
    fe_model i_fe (.i_clk(clk), .i_tick(tick), .i_up(up), .i_down(down), .i_sample(smp),
        .i_load(load), .i_imp(imp), .o_trip(trip), .o_level(lvl), .o_empty(empty),
        .o_ready(rdy), .o_vec(vec));
    // clock, reset held for eight cycles
    always #5 clk = ~clk;
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // expected mic result word from the sensed ranges and the mask
    function automatic logic [31:0] mexp(logic [8:0] v, logic [7:0] k);
        logic [8:0] g;
        g = {v[8] & k[7], 1'b0, v[6:1] & k[5:0], v[0]};
        return {21'h0, g, 1'b1, |g};
    endfunction : mexp
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // axi4-lite write, each channel released when taken
    task automatic wr(input logic [7:0] ix, input logic [15:0] d);
        aw  <= {2'b0, ix, 2'b0};
        wd  <= {16'h0, d};
        awv <= 1'b1;
        wv  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrr) wv <= 1'b0;
        end while (!bv);
        resp = br;
    endtask : wr
    task automatic rc(input logic [7:0] ix, input logic [31:0] e);
        ar  <= {2'b0, ix, 2'b0};
        arv <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        rd_d = rdata;
        resp = rr;
        chk(rd_d, e);
    endtask : rc
    // wait for the interrupt, counting mic sample requests on the way
    task automatic wirq();
        ns = 0;
        while (irq !== 1'b1)
        begin
            @(posedge clk);
            if (smp === 1'b1)
                ns++;
        end
    endtask : wirq
    task automatic complete_run();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        rc(`IDX_HPC, 32'h20);
        rc(`IDX_MICC, 32'h7600);
        rc(`IDX_MASK, 32'hbf);
        rc(`IDX_HPR, 32'h0);
        wr(8'h32, 16'hffff);
        chk(32'(resp), 32'h2);
        rc(8'h3e, 32'h0);
        chk(32'(resp), 32'h2);
        for (int i = 0; i < 3; i++)
        begin
            p = 3'(rnd());
            wr(`IDX_MODE, 16'(i));
            wr(`IDX_PIN, 16'(p));
            chk(32'({msel, pins}), 32'({i[1:0], p}));
        end
        wr(`IDX_IRQ_MSK, 16'h7);
        load <= 7'(rnd() % 8);
        wr(`IDX_HPC, 16'h0003);
        chk(32'(step), 32'h1);
        rc(`IDX_HPR, 32'h0);
        wirq();
        rc(`IDX_HPR, 32'h88);
        wr(`IDX_IRQ_MSK, 16'h0);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        wr(`IDX_IRQ_STS, 16'h1);
        wr(`IDX_IRQ_MSK, 16'h7);
        @(posedge clk);
        chk(32'(irq), 32'h0);
        load <= 7'(8 + rnd() % 119);
        wr(`IDX_HPC, 16'h0001);
        rc(`IDX_HPR, 32'h08);
        wirq();
        rc(`IDX_HPR, {24'h0, 1'b1, load});
        wr(`IDX_IRQ_STS, 16'h1);
        wr(`IDX_HPC, 16'h0008);
        repeat (2) @(posedge tick);
        t0 = $time;
        @(posedge tick);
        chk(32'(($time - t0) / 10), 32'd6250);
        m = 8'(rnd()) & 8'hbf;
        imp <= 9'(rnd()) & 9'h17f;
        wr(`IDX_MASK, {8'h0, m});
        wr(`IDX_MICC, 16'h0001);
        chk(32'(men), 32'h1);
        wirq();
        chk(32'(ns), 32'd2);
        rc(`IDX_MICR, mexp(imp, m));
        wr(`IDX_MICC, 16'h0);
        rc(`IDX_MICR, mexp(imp, m) & ~32'h2);
        // bias off: settle delay, then four agreeing results; low byte written alone
        bias <= 1'b0;
        wr(`IDX_IRQ_STS, 16'h7);
        wr(`IDX_MICC, 16'h2100);
        ws <= 4'h1;
        wr(`IDX_MICC, 16'hff03);
        ws <= 4'hf;
        nc = 0;
        while (smp !== 1'b1)
        begin
            @(posedge clk);
            nc++;
        end
        chk(32'(nc >= 20 && nc <= 45), 32'h1);
        wirq();
        chk(32'(ns), 32'd3);
        rc(`IDX_MICC, 32'h2103);
        complete_run();
    end
    // watchdog against a hung handshake
    initial
    begin
        #900000;
        n_fail++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
